// File: byx_alu.sv
// package of shared constants and the byte alu used by the executer
package byx_pkg;
  localparam logic [4:0]  FILE_INDIRECT  = 5'h00;
  localparam logic [4:0]  FILE_TIMER     = 5'h01;
  localparam logic [4:0]  FILE_PC_LOW    = 5'h02;
  localparam logic [4:0]  FILE_STATUS    = 5'h03;
  localparam logic [4:0]  FILE_PORT_A    = 5'h05;
  localparam logic [4:0]  FILE_PORT_C    = 5'h07;
  localparam int          ST_C_BIT       = 0;
  localparam int          ST_DC_BIT      = 1;
  localparam int          ST_Z_BIT       = 2;
  localparam int          ST_PAGE_LO     = 5;
  localparam int          ST_PAGE_HI     = 6;
  localparam int          PC_FORCED_BIT  = 8;
  localparam int          INSTR_DEST_BIT = 5;
  localparam logic [5:0]  OP_ADD         = 6'h07;
  localparam logic [5:0]  OP_AND         = 6'h05;
  localparam logic [6:0]  OP_MOVWF       = 7'h01;
  localparam logic [8:0]  OP_DIR_LOAD    = 9'h000;
  localparam logic [2:0]  OP_BRANCH      = 3'h5;
  localparam logic [7:0]  STATUS_RST     = 8'h00;
  localparam logic [7:0]  DIR_RST        = 8'hff;
  localparam logic [7:0]  LATCH_RST      = 8'h00;
  localparam logic [10:0] PC_RST         = 11'h7ff;
  localparam logic [7:0]  PRESC_MAX      = 8'hff;
  localparam logic [7:0]  AXI_CTRL       = 8'h00;
  localparam logic [7:0]  AXI_ACC        = 8'h04;
  localparam logic [7:0]  AXI_STATUS     = 8'h08;
  localparam logic [7:0]  AXI_PC         = 8'h0c;
  localparam logic [7:0]  AXI_TIMER      = 8'h10;
  localparam logic [7:0]  AXI_DIR        = 8'h14;
  localparam logic [7:0]  AXI_LATCH      = 8'h18;
  localparam int          CTRL_PRESC_BIT = 0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    BYX_EXEC  = 2'b01,
    BYX_FLUSH = 2'b10
  } byx_state_t;
endpackage : byx_pkg

`timescale 1ns/1ps
`default_nettype none

module byx_alu (
  input  wire logic       do_and,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] fval,
  output logic      [7:0] result,
  output logic            carry,
  output logic            digit_carry,
  output logic            zero
);
  wire logic [8:0] sum_full = {1'b0, acc} + {1'b0, fval};
  wire logic [4:0] sum_low  = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};

  assign result      = do_and ? (acc & fval) : sum_full[7:0];
  assign carry       = sum_full[8];
  assign digit_carry = sum_low[4];
  assign zero        = (result == 8'h00);
endmodule : byx_alu

`default_nettype wire

// File: byx_core.sv
// byte-operation executer with port latches, timer and an axi4-lite view
// Summary of operation
// - pc writes except branch clear pc bit
// - port read-modify-write uses pin levels
// - direction load 5/6/7 copies accumulator
// - direction bit one tristates the pin
// - timer write clears assigned prescaler
// - add sums, updates carry, digit carry, zero
// - and updates only zero flag
// - destination zero accumulator, one file
// - five-bit field addresses registers 0..31
// - instruction bit five is destination select
// - branch takes page bits from status
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module byx_core #(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       instr_word,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  output logic      [10:0]       pc_out,
  input  wire logic [PORT_W-1:0] port_a_in,
  output logic      [PORT_W-1:0] port_a_out,
  output logic      [PORT_W-1:0] port_a_oe_n,
  input  wire logic [PORT_W-1:0] port_b_in,
  output logic      [PORT_W-1:0] port_b_out,
  output logic      [PORT_W-1:0] port_b_oe_n,
  input  wire logic [PORT_W-1:0] port_c_in,
  output logic      [PORT_W-1:0] port_c_out,
  output logic      [PORT_W-1:0] port_c_oe_n,
  output logic                   presc_clear,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  byx_pkg::byx_state_t state_reg;
  byx_pkg::byx_state_t state_next;
  logic [10:0]       pc_reg;
  logic [7:0]        acc_reg;
  logic [7:0]        status_reg;
  logic [7:0]        timer_counter_reg;
  logic [7:0]        presc_reg;
  logic              presc_assign_reg;
  logic              presc_clear_reg;
  logic [7:0]        ram_reg [0:31];
  logic [PORT_W-1:0] latch_reg [0:2];
  logic [PORT_W-1:0] dir_reg [0:2];
  logic [PORT_W-1:0] pins [0:2];

  assign pins[0] = port_a_in;
  assign pins[1] = port_b_in;
  assign pins[2] = port_c_in;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic       exec       = instr_valid && (state_reg == byx_pkg::BYX_EXEC);
  wire logic [4:0] f_addr     = instr_word[4:0];
  wire logic       dest_file  = instr_word[byx_pkg::INSTR_DEST_BIT];
  wire logic       is_add     = instr_word[11:6] == byx_pkg::OP_ADD;
  wire logic       is_and     = instr_word[11:6] == byx_pkg::OP_AND;
  wire logic       is_movwf   = instr_word[11:5] == byx_pkg::OP_MOVWF;
  wire logic       is_branch  = instr_word[11:9] == byx_pkg::OP_BRANCH;
  wire logic       is_dir     = (instr_word[11:3] == byx_pkg::OP_DIR_LOAD)
                                && (instr_word[2:0] >= byx_pkg::FILE_PORT_A[2:0]);
  wire logic       is_byte_op = is_add || is_and;
  wire logic       is_port    = (f_addr >= byx_pkg::FILE_PORT_A) && (f_addr <= byx_pkg::FILE_PORT_C);
  wire logic [1:0] port_idx   = 2'(f_addr - byx_pkg::FILE_PORT_A);
  wire logic [1:0] dir_idx    = 2'(instr_word[2:0] - byx_pkg::FILE_PORT_A[2:0]);

  // port operands come from the pins so input bits never echo the latch
  wire logic [7:0] port_val   = 8'(pins[port_idx]);
  wire logic [7:0] file_val   = (f_addr == byx_pkg::FILE_INDIRECT) ? 8'h00 :
                                (f_addr == byx_pkg::FILE_TIMER)    ? timer_counter_reg :
                                (f_addr == byx_pkg::FILE_PC_LOW)   ? pc_reg[7:0] :
                                (f_addr == byx_pkg::FILE_STATUS)   ? status_reg :
                                is_port                            ? port_val : ram_reg[f_addr];

  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;

  byx_alu u_alu (
    .do_and      (is_and),
    .acc         (acc_reg),
    .fval        (file_val),
    .result      (alu_res),
    .carry       (alu_c),
    .digit_carry (alu_dc),
    .zero        (alu_z)
  );

  wire logic       wr_file    = exec && ((is_byte_op && dest_file) || is_movwf);
  wire logic       wr_acc     = exec && is_byte_op && !dest_file;
  wire logic [7:0] wr_val     = is_movwf ? acc_reg : alu_res;
  wire logic       wr_timer   = wr_file && (f_addr == byx_pkg::FILE_TIMER);
  wire logic       wr_pcl     = wr_file && (f_addr == byx_pkg::FILE_PC_LOW);
  wire logic       wr_status  = wr_file && (f_addr == byx_pkg::FILE_STATUS);
  wire logic       do_branch  = exec && is_branch;
  wire logic [1:0] page_bits  = status_reg[byx_pkg::ST_PAGE_HI:byx_pkg::ST_PAGE_LO];

  ////////////////////////////////////////////////////////////////////////////
  // next values
  logic [10:0] pc_next;
  logic [7:0]  status_next;

  always_comb begin
    pc_next = pc_reg;
    if (do_branch) begin
      pc_next = {page_bits, instr_word[8:0]};
    end else if (wr_pcl) begin
      pc_next = {page_bits, 1'b0, wr_val};
    end else if (exec) begin
      pc_next = pc_reg + 11'h001;
    end
  end

  always_comb begin
    status_next = wr_status ? wr_val : status_reg;
    if (exec && is_add) begin
      status_next[byx_pkg::ST_C_BIT]  = alu_c;
      status_next[byx_pkg::ST_DC_BIT] = alu_dc;
      status_next[byx_pkg::ST_Z_BIT]  = alu_z;
    end else if (exec && is_and) begin
      status_next[byx_pkg::ST_Z_BIT]  = alu_z;
    end
  end

  // a pc change discards the word already fetched, so it costs a cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      byx_pkg::BYX_EXEC: begin
        if (do_branch || wr_pcl) begin
          state_next = byx_pkg::BYX_FLUSH;
        end
      end
      byx_pkg::BYX_FLUSH: begin
        if (instr_valid) begin
          state_next = byx_pkg::BYX_EXEC;
        end
      end
      default: begin
        state_next = byx_pkg::BYX_EXEC;
      end
    endcase
  end

  // add and and finish in this one cycle, nothing stalls them
  assign instr_ready = (state_reg == byx_pkg::BYX_EXEC) || (state_reg == byx_pkg::BYX_FLUSH);
  assign pc_out      = pc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= byx_pkg::BYX_EXEC;
      pc_reg     <= byx_pkg::PC_RST;
      acc_reg    <= 8'h00;
      status_reg <= byx_pkg::STATUS_RST;
    end else begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      status_reg <= status_next;
      if (wr_acc) begin
        acc_reg <= alu_res;
      end
    end
  end

  // general file registers carry no reset, like plain ram
  always_ff @(posedge aclk) begin
    if (wr_file && (f_addr > byx_pkg::FILE_PORT_C || f_addr == 5'h04)) begin
      ram_reg[f_addr] <= wr_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer and prescaler
  wire logic presc_wrap = presc_reg == byx_pkg::PRESC_MAX;
  wire logic timer_tick = presc_assign_reg ? presc_wrap : 1'b1;
  wire logic presc_clr  = wr_timer && presc_assign_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_counter_reg <= 8'h00;
      presc_reg         <= 8'h00;
      presc_clear_reg   <= 1'b0;
    end else begin
      presc_clear_reg <= presc_clr;
      if (presc_clr || !presc_assign_reg) begin
        presc_reg <= 8'h00;
      end else begin
        presc_reg <= presc_reg + 8'h01;
      end
      if (wr_timer) begin
        timer_counter_reg <= wr_val;
      end else if (timer_tick) begin
        timer_counter_reg <= timer_counter_reg + 8'h01;
      end
    end
  end
  assign presc_clear = presc_clear_reg;

  ////////////////////////////////////////////////////////////////////////////
  // port latches and direction latches
  for (genvar p = 0; p < 3; p++) begin : g_port
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        latch_reg[p] <= PORT_W'(byx_pkg::LATCH_RST);
        dir_reg[p]   <= PORT_W'(byx_pkg::DIR_RST);
      end else begin
        if (wr_file && is_port && port_idx == 2'(p)) begin
          latch_reg[p] <= PORT_W'(wr_val);
        end
        if (exec && is_dir && dir_idx == 2'(p)) begin
          dir_reg[p] <= PORT_W'(acc_reg);
        end
      end
    end
  end

  // a set direction bit lifts the output enable, leaving the pin floating
  assign port_a_out  = latch_reg[0];
  assign port_b_out  = latch_reg[1];
  assign port_c_out  = latch_reg[2];
  assign port_a_oe_n = dir_reg[0];
  assign port_b_oe_n = dir_reg[1];
  assign port_c_oe_n = dir_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  assign awready = !aw_full_reg && !bvalid_reg;
  assign wready  = !w_full_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  wire logic       aw_take   = awvalid && awready;
  wire logic       w_take    = wvalid && wready;
  wire logic       wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
  wire logic [7:0] wr_off    = 8'(aw_addr_reg);
  wire logic       wr_ctrl   = wr_off == byx_pkg::AXI_CTRL;
  wire logic       wr_known  = wr_ctrl || wr_off == byx_pkg::AXI_ACC || wr_off == byx_pkg::AXI_STATUS ||
                               wr_off == byx_pkg::AXI_PC || wr_off == byx_pkg::AXI_TIMER ||
                               wr_off == byx_pkg::AXI_DIR || wr_off == byx_pkg::AXI_LATCH;
  wire logic [7:0] rd_off    = 8'(araddr);
  wire logic [31:0] rd_mux   =
    (rd_off == byx_pkg::AXI_CTRL)   ? {31'h0, presc_assign_reg} :
    (rd_off == byx_pkg::AXI_ACC)    ? {24'h0, acc_reg} :
    (rd_off == byx_pkg::AXI_STATUS) ? {24'h0, status_reg} :
    (rd_off == byx_pkg::AXI_PC)     ? {21'h0, pc_reg} :
    (rd_off == byx_pkg::AXI_TIMER)  ? {16'h0, presc_reg, timer_counter_reg} :
    (rd_off == byx_pkg::AXI_DIR)    ? {8'h0, 8'(dir_reg[2]), 8'(dir_reg[1]), 8'(dir_reg[0])} :
    (rd_off == byx_pkg::AXI_LATCH)  ? {8'h0, 8'(latch_reg[2]), 8'(latch_reg[1]), 8'(latch_reg[0])} :
                                      32'h0;
  wire logic       rd_known  = rd_off <= byx_pkg::AXI_LATCH && rd_off[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg      <= 1'b0;
      w_full_reg       <= 1'b0;
      aw_addr_reg      <= '0;
      w_data_reg       <= 32'h0;
      w_strb_reg       <= 4'h0;
      bvalid_reg       <= 1'b0;
      bresp_reg        <= byx_pkg::RESP_OKAY;
      presc_assign_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? byx_pkg::RESP_OKAY : byx_pkg::RESP_SLVERR;
        if (wr_ctrl && w_strb_reg[0]) begin
          presc_assign_reg <= w_data_reg[byx_pkg::CTRL_PRESC_BIT];
        end
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= byx_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_known ? byx_pkg::RESP_OKAY : byx_pkg::RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule : byx_core

`default_nettype wire

// File: byx_core_properties.sv
// checker on the instruction port, pc and pin outputs of the byte executer
`timescale 1ns/1ps
`default_nettype none
module byx_core_props #(
  parameter int PORT_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [11:0]       instr_word,
  input wire logic              instr_valid,
  input wire logic [10:0]       pc_out,
  input wire logic [PORT_W-1:0] port_a_in,
  input wire logic [PORT_W-1:0] port_a_out,
  input wire logic [PORT_W-1:0] port_b_out,
  input wire logic [PORT_W-1:0] port_b_oe_n,
  input wire logic [PORT_W-1:0] port_c_out,
  input wire logic [PORT_W-1:0] port_c_oe_n,
  input wire logic              presc_clear
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic flush_reg;
  wire logic [5:0] opc     = instr_word[11:6];
  wire logic [4:0] fld     = instr_word[4:0];
  wire logic       is_alu  = opc == byx_pkg::OP_ADD || opc == byx_pkg::OP_AND;
  wire logic       is_mov  = instr_word[11:5] == byx_pkg::OP_MOVWF;
  wire logic       file_wr = is_mov || (is_alu && instr_word[5]);
  wire logic       is_br   = instr_word[11:9] == byx_pkg::OP_BRANCH;
  wire logic       taken   = instr_valid && !flush_reg;
  wire logic       jump    = is_br || (file_wr && fld == byx_pkg::FILE_PC_LOW);
  // a taken jump discards the following word, so only executed words count
  always_ff @(posedge aclk) begin
    if (!aresetn) flush_reg <= 1'b0;
    else if (instr_valid) flush_reg <= taken && jump;
  end
  ////////////////////////////////////////////////////////////////
  chk_alu_one_step: assert property (taken && is_alu && !jump |=> pc_out == $past(pc_out) + 11'h001)
    else $error("pc did not advance by one after an alu word");
  chk_branch_low: assert property (taken && is_br |=> pc_out[8:0] == $past(instr_word[8:0]))
    else $error("branch target bits not loaded");
  chk_pc_bit_force: assert property (taken && file_wr && fld == byx_pkg::FILE_PC_LOW |=> !pc_out[8])
    else $error("pc bit eight not cleared on pc write");
  chk_dir_a_only: assert property (taken && instr_word == 12'h005
      |=> $stable(port_b_oe_n) && $stable(port_c_oe_n))
    else $error("direction load of port a touched another port");
  chk_presc_cause: assert property (presc_clear |-> $past(taken && file_wr && fld == byx_pkg::FILE_TIMER))
    else $error("prescaler cleared without a timer write");
  chk_dest_acc: assert property (taken && is_alu && !instr_word[5]
      |=> $stable({port_a_out, port_b_out, port_c_out}))
    else $error("accumulator destination changed a port latch");
  chk_and_pins: assert property (taken && opc == byx_pkg::OP_AND && instr_word[5] && fld == byx_pkg::FILE_PORT_A
      |=> (port_a_out & ~$past(port_a_in)) == '0)
    else $error("port and result not bounded by pin levels");
  chk_file_field: assert property (taken && is_mov && fld > byx_pkg::FILE_PORT_C
      |=> $stable({port_a_out, port_c_out}))
    else $error("ram write disturbed a port latch");
endmodule : byx_core_props
`default_nettype wire

// File: byx_core_tb.sv
// self-checking bench for the byte executer: instruction port, pins and register bus
`timescale 1ns/1ps
`default_nettype none
module byx_core_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, instr_valid = 1'b0, pc_known = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] instr_word = 12'h000;
  logic [10:0] pc_e = 11'h7ff;
  logic [7:0]  pa = 8'h00, pb = 8'h44, pcn = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        instr_ready, presc_clear, awready, wready, bvalid, arready, rvalid;
  logic [10:0] pc_out;
  logic [7:0]  oa, ea, ob, eb, oc, ec;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_total = 0, samples_checked = 0, cyc = 0, pulses = 0, p0;
  localparam logic [1:0] OK = byx_pkg::RESP_OKAY;

  byx_core #(.PORT_W(8), .ADDR_W(8)) byx_core_i (
    .aclk(aclk), .aresetn(aresetn), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .pc_out(pc_out), .port_a_in(pa), .port_a_out(oa), .port_a_oe_n(ea),
    .port_b_in(pb), .port_b_out(ob), .port_b_oe_n(eb), .port_c_in(pcn), .port_c_out(oc),
    .port_c_oe_n(ec), .presc_clear(presc_clear), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  always #20 aclk = ~aclk;
  always @(posedge aclk) if (presc_clear === 1'b1) pulses <= pulses + 1;
  // a hang ends the run through the same verdict
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  function automatic logic [11:0] op(input logic [5:0] o, input logic d, input logic [4:0] f);
    return {o, d, f};
  endfunction : op

  task automatic exec(input logic [11:0] w);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge aclk);
    instr_valid <= 1'b0;
    @(posedge aclk);
    pc_e = pc_e + 11'h001;
    chk({31'h0, instr_ready}, 32'h1, "instr ready");
    if (pc_known) chk({21'h0, pc_out}, {21'h0, pc_e}, "pc");
  endtask : exec

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // ready stays up between calls so no signal is driven twice in one step
    chk({30'h0, bresp}, {30'h0, r}, "bresp");
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, e, "rdata");
    chk({30'h0, rresp}, {30'h0, r}, "rresp");
  endtask : axr
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(byx_pkg::AXI_ACC, 32'h0, OK);
    axr(byx_pkg::AXI_PC, 32'h7ff, OK);
    axr(byx_pkg::AXI_DIR, 32'hffffff, OK);
    axr(8'h40, 32'h0, byx_pkg::RESP_SLVERR);
    pa <= 8'hc2;
    exec(op(byx_pkg::OP_ADD, 1'b0, byx_pkg::FILE_PORT_A));
    exec(op(6'h00, 1'b1, 5'h09));
    pa <= 8'h55;
    exec(op(byx_pkg::OP_ADD, 1'b0, byx_pkg::FILE_PORT_A));
    axr(byx_pkg::AXI_ACC, 32'h17, OK);
    exec(op(byx_pkg::OP_AND, 1'b1, byx_pkg::FILE_PORT_A));
    chk({24'h0, oa}, 32'h15, "and to port a");
    exec(op(byx_pkg::OP_AND, 1'b1, 5'h09));
    axr(byx_pkg::AXI_STATUS, 32'h01, OK);
    exec(op(byx_pkg::OP_ADD, 1'b0, 5'h09));
    axr(byx_pkg::AXI_ACC, 32'h19, OK);
    axr(byx_pkg::AXI_STATUS, 32'h00, OK);
    exec(12'h006);
    exec(op(6'h00, 1'b1, 5'h06));
    exec(op(byx_pkg::OP_ADD, 1'b1, 5'h06));
    chk({24'h0, ob}, 32'h5d, "add back to port b");
    axr(byx_pkg::AXI_ACC, 32'h19, OK);
    pa <= 8'he7;
    exec(op(byx_pkg::OP_ADD, 1'b0, byx_pkg::FILE_PORT_A));
    axr(byx_pkg::AXI_ACC, 32'h00, OK);
    axr(byx_pkg::AXI_STATUS, 32'h07, OK);
    exec(12'h005);
    exec(12'h007);
    axr(byx_pkg::AXI_DIR, 32'h001900, OK);
    chk({24'h0, ea}, 32'h0, "port a driven");
    chk({24'h0, eb}, 32'h19, "port b enables");
    chk({24'h0, ec}, 32'h0, "port c driven");
    exec(op(byx_pkg::OP_ADD, 1'b0, 5'h06));
    exec(op(6'h00, 1'b1, byx_pkg::FILE_STATUS));
    axr(byx_pkg::AXI_STATUS, 32'h44, OK);
    pc_e = 11'h5fe;
    exec(12'hbff);
    pc_known = 1'b0;
    exec(op(byx_pkg::OP_ADD, 1'b0, 5'h06));
    pc_e = 11'h443;
    pc_known = 1'b1;
    exec(op(6'h00, 1'b1, byx_pkg::FILE_PC_LOW));
    pc_known = 1'b0;
    exec(12'h000);
    axr(byx_pkg::AXI_ACC, 32'h44, OK);
    pcn <= 8'h3c;
    exec(op(byx_pkg::OP_AND, 1'b1, byx_pkg::FILE_PORT_C));
    chk({24'h0, oc}, 32'h04, "and to port c");
    axw(byx_pkg::AXI_CTRL, 32'h1, OK);
    axr(byx_pkg::AXI_CTRL, 32'h1, OK);
    p0 = pulses;
    exec(op(byx_pkg::OP_ADD, 1'b0, byx_pkg::FILE_TIMER));
    exec(op(byx_pkg::OP_ADD, 1'b1, byx_pkg::FILE_TIMER));
    exec(op(6'h00, 1'b1, byx_pkg::FILE_TIMER));
    repeat (2) @(posedge aclk);
    chk(pulses - p0, 32'h2, "prescaler clears");
    axw(byx_pkg::AXI_CTRL, 32'h0, OK);
    exec(op(6'h00, 1'b1, byx_pkg::FILE_TIMER));
    repeat (2) @(posedge aclk);
    chk(pulses - p0, 32'h2, "clear while unassigned");
    axw(byx_pkg::AXI_DIR, 32'h0, OK);
    axr(byx_pkg::AXI_DIR, 32'h001900, OK);
    axw(8'h44, 32'h0, byx_pkg::RESP_SLVERR);
    close_out();
  end
endmodule : byx_core_tb

bind byx_core byx_core_props #(.PORT_W(PORT_W)) byx_core_props_i (
  .aclk(aclk), .aresetn(aresetn), .instr_word(instr_word), .instr_valid(instr_valid), .pc_out(pc_out),
  .port_a_in(port_a_in), .port_a_out(port_a_out), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
  .port_c_out(port_c_out), .port_c_oe_n(port_c_oe_n), .presc_clear(presc_clear));
`default_nettype wire
